/* File: hw/tccr_pkg.sv */
// Package with register map, field positions, reset values and carrier types of the timer block.
package tccr_pkg;

  // Bus and datapath widths.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int PRE_W = 6;
  localparam int NCH = 2;

  // Register offsets; the channel registers repeat with a stride of three.
  localparam logic [ADDR_W-1:0] A_TSC = 4'h0;
  localparam logic [ADDR_W-1:0] A_CNT_HI = 4'h1;
  localparam logic [ADDR_W-1:0] A_CNT_LO = 4'h2;
  localparam logic [ADDR_W-1:0] A_MOD_HI = 4'h3;
  localparam logic [ADDR_W-1:0] A_MOD_LO = 4'h4;
  localparam logic [ADDR_W-1:0] A_CH0_SC = 4'h5;
  localparam logic [ADDR_W-1:0] A_CH0_HI = 4'h6;
  localparam logic [ADDR_W-1:0] A_CH0_LO = 4'h7;
  localparam logic [ADDR_W-1:0] A_CH_STRIDE = 4'h3;

  // Field positions in the timer status/control register.
  localparam int TSC_FLAG = 7;
  localparam int TSC_IE = 6;
  localparam int TSC_HALT = 5;
  localparam int TSC_CLR = 4;
  localparam int TSC_PS_LO = 0;

  // Field positions in a channel status/control register.
  localparam int CSC_FLAG = 7;
  localparam int CSC_IE = 6;
  localparam int CSC_MSB = 5;
  localparam int CSC_MSA = 4;
  localparam int CSC_ELS_LO = 2;
  localparam int CSC_TOV = 1;
  localparam int CSC_MAX = 0;

  // Prescaler code that selects no clock.
  localparam logic [2:0] PS_NONE = 3'h7;

  // Values after reset.
  localparam logic [CNT_W-1:0] MOD_RST = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // One register bus request, as driven by the bus master.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tccr_bus_req_t;

  // State of one capture/compare channel.
  typedef struct packed {
    logic flag;
    logic ie;
    logic msb;
    logic msa;
    logic [1:0] els;
    logic tov;
    logic max;
    logic armed;
    logic inhibit;
    logic out;
    logic pin_q;
    logic [CNT_W-1:0] val;
  } tccr_chan_t;

  // Whole state of the timer.
  typedef struct packed {
    logic ovf_flag;
    logic ovf_armed;
    logic ovf_ie;
    logic halt;
    logic [2:0] ps;
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] modv;
    logic mod_block;
    logic lo_latched;
    logic [DATA_W-1:0] lo_buf;
    logic buf_act;
    logic buf_last;
    tccr_chan_t [NCH-1:0] ch;
    logic [DATA_W-1:0] rdata;
  } tccr_state_t;

endpackage : tccr_pkg

/* File: hw/tccr_timer.sv */
// Timer with prescaler, modulo counter and two capture/compare channels behind a byte register port.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module tccr_timer (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port.
  input wire tccr_pkg::tccr_bus_req_t i_bus,
  output logic [tccr_pkg::DATA_W-1:0] o_rdata,
  // Interrupt requests.
  output logic o_ovf_irq,
  output logic [tccr_pkg::NCH-1:0] o_ch_irq,
  // Channel pins.
  input wire logic [tccr_pkg::NCH-1:0] i_pin,
  output logic [tccr_pkg::NCH-1:0] o_pin,
  output logic [tccr_pkg::NCH-1:0] o_pin_oe
);

  tccr_pkg::tccr_state_t s;
  tccr_pkg::tccr_state_t n;

  logic [tccr_pkg::PRE_W-1:0] pre_mask;
  logic tick;
  logic wrap;
  logic [tccr_pkg::NCH-1:0] ch_en;
  logic [tccr_pkg::NCH-1:0] is_cap;
  logic [tccr_pkg::NCH-1:0] is_cmp;
  logic [tccr_pkg::NCH-1:0] cap_ev;
  logic [tccr_pkg::NCH-1:0] cmp_ev;
  logic [tccr_pkg::CNT_W-1:0] cmp_val;
  logic [tccr_pkg::ADDR_W-1:0] a_sc;
  logic [tccr_pkg::ADDR_W-1:0] a_hi;
  logic [tccr_pkg::ADDR_W-1:0] a_lo;
  logic rd;
  logic wr;
  logic [tccr_pkg::DATA_W-1:0] wd;

  // Next-state logic: counting, events, then bus side effects, then hardware sets over clears.
  always_comb begin
    n = s;
    rd = i_bus.rd;
    wr = i_bus.wr;
    wd = i_bus.wdata;
    pre_mask = tccr_pkg::PRE_W'((7'h01 << s.ps) - 7'h01);
    tick = (s.ps != tccr_pkg::PS_NONE) && ((s.pre & pre_mask) == pre_mask) && !s.halt;
    wrap = tick && (s.cnt == s.modv);
    ch_en = '1;
    is_cap = '0;
    is_cmp = '0;
    cap_ev = '0;
    cmp_ev = '0;
    cmp_val = '0;
    a_sc = '0;
    a_hi = '0;
    a_lo = '0;

    // Prescaler and counter run only while not halted.
    if (!s.halt) begin
      n.pre = s.pre + 1'b1;
    end
    if (tick) begin
      if (wrap) begin
        n.cnt = tccr_pkg::CNT_RST;
        n.buf_act = s.buf_last;
      end else begin
        n.cnt = s.cnt + 1'b1;
      end
    end

    // Channel events are judged on the registered state of this cycle.
    for (int i = 0; i < tccr_pkg::NCH; i++) begin
      ch_en[i] = !(i == 1 && s.ch[0].msb);
      is_cap[i] = ch_en[i] && !s.ch[i].msb && !s.ch[i].msa && (s.ch[i].els != 2'h0);
      is_cmp[i] = ch_en[i] && (s.ch[i].msb || s.ch[i].msa) && (s.ch[i].els != 2'h0);
      cmp_val = (i == 0 && s.ch[0].msb) ? s.ch[s.buf_act].val : s.ch[i].val;
      cap_ev[i] = is_cap[i] && !s.ch[i].inhibit &&
                  ((s.ch[i].els[0] && i_pin[i] && !s.ch[i].pin_q) ||
                   (s.ch[i].els[1] && !i_pin[i] && s.ch[i].pin_q));
      cmp_ev[i] = is_cmp[i] && !s.ch[i].inhibit && tick && (s.cnt == cmp_val);
      n.ch[i].pin_q = i_pin[i];
      if (cap_ev[i]) begin
        n.ch[i].val = s.cnt;
      end
      // Pin level: preset while disconnected, wrap toggle beats compare action.
      if (s.ch[i].els == 2'h0) begin
        n.ch[i].out = !s.ch[i].msa;
      end else if (is_cmp[i]) begin
        if (wrap && s.ch[i].tov) begin
          n.ch[i].out = !s.ch[i].out;
        end else if (cmp_ev[i]) begin
          unique case (s.ch[i].els)
            2'h1: n.ch[i].out = !s.ch[i].out;
            2'h2: n.ch[i].out = 1'b0;
            2'h3: n.ch[i].out = 1'b1;
            default: n.ch[i].out = s.ch[i].out;
          endcase
        end
      end
    end

    // Read data and read side effects.
    n.rdata = '0;
    if (rd) begin
      unique case (i_bus.addr)
        tccr_pkg::A_TSC: begin
          n.rdata[tccr_pkg::TSC_FLAG] = s.ovf_flag;
          n.rdata[tccr_pkg::TSC_IE] = s.ovf_ie;
          n.rdata[tccr_pkg::TSC_HALT] = s.halt;
          n.rdata[tccr_pkg::TSC_PS_LO +: 3] = s.ps;
          if (s.ovf_flag) begin
            n.ovf_armed = 1'b1;
          end
        end
        tccr_pkg::A_CNT_HI: begin
          n.rdata = s.cnt[15:8];
          if (!s.lo_latched) begin
            n.lo_latched = 1'b1;
            n.lo_buf = s.cnt[7:0];
          end
        end
        tccr_pkg::A_CNT_LO: begin
          n.rdata = s.lo_latched ? s.lo_buf : s.cnt[7:0];
          n.lo_latched = 1'b0;
        end
        tccr_pkg::A_MOD_HI: n.rdata = s.modv[15:8];
        tccr_pkg::A_MOD_LO: n.rdata = s.modv[7:0];
        default: n.rdata = '0;
      endcase
    end

    // Writes to the timer registers; the counter bytes take no write.
    if (wr) begin
      unique case (i_bus.addr)
        tccr_pkg::A_TSC: begin
          if (!wd[tccr_pkg::TSC_FLAG] && s.ovf_armed) begin
            n.ovf_flag = 1'b0;
            n.ovf_armed = 1'b0;
          end
          n.ovf_ie = wd[tccr_pkg::TSC_IE];
          n.halt = wd[tccr_pkg::TSC_HALT];
          n.ps = wd[tccr_pkg::TSC_PS_LO +: 3];
          if (wd[tccr_pkg::TSC_CLR]) begin
            n.cnt = tccr_pkg::CNT_RST;
            n.pre = '0;
            n.buf_act = s.buf_act;
          end
        end
        tccr_pkg::A_MOD_HI: begin
          n.modv[15:8] = wd;
          n.mod_block = 1'b1;
        end
        tccr_pkg::A_MOD_LO: begin
          n.modv[7:0] = wd;
          n.mod_block = 1'b0;
        end
        default: n.mod_block = n.mod_block;
      endcase
    end

    // Channel register accesses.
    for (int i = 0; i < tccr_pkg::NCH; i++) begin
      a_sc = tccr_pkg::ADDR_W'(tccr_pkg::A_CH0_SC + i * tccr_pkg::A_CH_STRIDE);
      a_hi = tccr_pkg::ADDR_W'(tccr_pkg::A_CH0_HI + i * tccr_pkg::A_CH_STRIDE);
      a_lo = tccr_pkg::ADDR_W'(tccr_pkg::A_CH0_LO + i * tccr_pkg::A_CH_STRIDE);
      if (rd && i_bus.addr == a_sc && ch_en[i]) begin
        n.rdata = {s.ch[i].flag, s.ch[i].ie, s.ch[i].msb, s.ch[i].msa,
                   s.ch[i].els, s.ch[i].tov, s.ch[i].max};
        if (s.ch[i].flag) begin
          n.ch[i].armed = 1'b1;
        end
      end
      if (rd && i_bus.addr == a_hi) begin
        n.rdata = s.ch[i].val[15:8];
        if (is_cap[i]) begin
          n.ch[i].inhibit = 1'b1;
        end
      end
      if (rd && i_bus.addr == a_lo) begin
        n.rdata = s.ch[i].val[7:0];
        if (is_cap[i]) begin
          n.ch[i].inhibit = 1'b0;
        end
      end
      if (wr && i_bus.addr == a_sc && ch_en[i]) begin
        if (!wd[tccr_pkg::CSC_FLAG] && s.ch[i].armed) begin
          n.ch[i].flag = 1'b0;
          n.ch[i].armed = 1'b0;
        end
        n.ch[i].ie = wd[tccr_pkg::CSC_IE];
        n.ch[i].msb = (i == 0) ? wd[tccr_pkg::CSC_MSB] : 1'b0;
        n.ch[i].msa = wd[tccr_pkg::CSC_MSA];
        n.ch[i].els = wd[tccr_pkg::CSC_ELS_LO +: 2];
        n.ch[i].tov = wd[tccr_pkg::CSC_TOV];
        n.ch[i].max = wd[tccr_pkg::CSC_MAX];
      end
      if (wr && i_bus.addr == a_hi) begin
        n.ch[i].val[15:8] = wd;
        n.buf_last = 1'(i);
        if (is_cmp[i]) begin
          n.ch[i].inhibit = 1'b1;
        end
      end
      if (wr && i_bus.addr == a_lo) begin
        n.ch[i].val[7:0] = wd;
        n.buf_last = 1'(i);
        n.ch[i].inhibit = 1'b0;
      end
      // A fresh event beats a clear in the same cycle and spoils any armed clear.
      if (cap_ev[i] || cmp_ev[i]) begin
        n.ch[i].flag = 1'b1;
        n.ch[i].armed = 1'b0;
      end
    end

    // Overflow set comes last so it wins over a clearing write.
    if (wrap && !s.mod_block) begin
      n.ovf_flag = 1'b1;
      n.ovf_armed = 1'b0;
    end
  end

  // State register; reset halts the counter and loads the modulo with all ones.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.halt <= 1'b1;
      s.modv <= tccr_pkg::MOD_RST;
      s.ch[0].out <= 1'b1;
      s.ch[1].out <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs; the pins are driven only in compare mode.
  assign o_rdata = s.rdata;
  assign o_ovf_irq = s.ovf_flag && s.ovf_ie;
  always_comb begin
    for (int i = 0; i < tccr_pkg::NCH; i++) begin
      o_ch_irq[i] = s.ch[i].flag && s.ch[i].ie;
      o_pin[i] = s.ch[i].out;
      o_pin_oe[i] = (s.ch[i].msb || s.ch[i].msa) && (s.ch[i].els != 2'h0) &&
                    !(i == 1 && s.ch[0].msb);
    end
  end

endmodule : tccr_timer

/* File: verif/tccr_timer_sva.sv */
// Checker of the timer's register port, interrupt requests and pins.
`timescale 1ns/1ps
module tccr_timer_sva (
  // Clock, reset and bus.
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire tccr_pkg::tccr_bus_req_t i_bus,
  // Observed outputs and pins.
  input wire logic [7:0] o_rdata,
  input wire logic o_ovf_irq,
  input wire logic [1:0] o_ch_irq,
  input wire logic [1:0] i_pin,
  input wire logic [1:0] o_pin,
  input wire logic [1:0] o_pin_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Decoded bus requests, so that each property looks back at one signal only.
  wire tsc_wr = i_bus.wr && i_bus.addr == 4'h0;
  wire tsc_rd = i_bus.rd && i_bus.addr == 4'h0;
  wire ch0_wr = i_bus.wr && i_bus.addr == 4'h5;
  wire one_wr = tsc_wr && i_bus.wdata[7:6] == 2'b11 && o_ovf_irq;
  wire unm_rd = i_bus.rd && i_bus.addr > 4'ha;

  rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data seen without a read");
  trst_zero_a: assert property ($past(tsc_rd) |-> !o_rdata[4])
    else $error("counter reset bit read as one");
  ovf_fall_a: assert property ($fell(o_ovf_irq) |-> $past(tsc_wr))
    else $error("overflow request dropped without a status write");
  ovf_one_a: assert property ($past(one_wr) |-> o_ovf_irq)
    else $error("writing one cleared the overflow flag");
  ch_fall_a: assert property ($fell(o_ch_irq[0]) |-> $past(ch0_wr))
    else $error("channel request dropped without a channel write");
  unmapped_a: assert property ($past(unm_rd) |-> o_rdata == 8'h00)
    else $error("unmapped read returned data");
  preset_a: assert property (!o_pin_oe[0] && $changed(o_pin[0]) |-> $past(i_bus.wr) || $past(i_bus.wr, 2))
    else $error("released pin level moved without a write");
  oe_reset_a: assert property ($rose(i_rst_n) |-> o_pin_oe == 2'b00 && !o_ovf_irq)
    else $error("pins driven or request raised after reset");

  // Main scenarios.
  ovf_clr_c: cover property ($fell(o_ovf_irq));
  cap_c: cover property ($rose(o_ch_irq[0]));
  drive_c: cover property ($rose(o_pin_oe[0]));
endmodule : tccr_timer_sva

/* File: verif/tccr_pins_model.sv */
// Behavioural model of the signal sources on the two channel pins.
`timescale 1ns/1ps
module tccr_pins_model (
  // Clock.
  input wire logic i_clk,
  // Timer pin drive.
  input wire logic [1:0] i_pin,
  input wire logic [1:0] i_pin_oe,
  // Resolved pin level.
  output logic [1:0] o_level
);
  logic [1:0] ext_ff = 2'b11;
  // A pin the timer drives shows the timer's level; the outside source only counts on released pins.
  assign o_level = (i_pin_oe & i_pin) | (~i_pin_oe & ext_ff);
  // The source moves just after an edge, as a synchronous input would.
  task automatic level(input int ch, input logic v);
    @(posedge i_clk);
    ext_ff[ch] <= v;
  endtask : level
endmodule : tccr_pins_model

/* File: verif/tb_top.sv */
// Self-checking bench of the timer over its register port and pins.
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  tccr_pkg::tccr_bus_req_t bus = '0;
  logic [7:0] rdata, d, l1, l2;
  logic [15:0] c;
  logic ovf_irq;
  logic [1:0] ch_irq, pin_in, pin_out, pin_oe;
  int error_cnt = 0;
  int n_checks = 0;

  // Free-running 250 MHz clock.
  always #2 i_clk = ~i_clk;

  // Timer and the pin model facing it.
  tccr_timer dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata), .o_ovf_irq(ovf_irq),
    .o_ch_irq(ch_irq), .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe(pin_oe));
  tccr_pins_model pins (.i_clk(i_clk), .i_pin(pin_out), .i_pin_oe(pin_oe), .o_level(pin_in));

  // Byte and flag comparisons.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bchk(input string n, input logic e, input logic g);
    chk(n, {7'h0, e}, {7'h0, g});
  endtask : bchk

  // Bus cycles end with an idle cycle, so no strobe is driven twice at one edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1 v = rdata;
    @(posedge i_clk);
  endtask : rd
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    rd(a, d);
    chk(n, e, d);
  endtask : rchk

  // Reset values.
  task automatic t_reset();
    rchk("status", 4'h0, 8'h20);
    rchk("mod_hi", 4'h3, 8'hff);
    rchk("mod_lo", 4'h4, 8'hff);
    rchk("cnt_lo", 4'h2, 8'h00);
    rchk("ch0_sc", 4'h5, 8'h00);
    chk("pins", 8'h0c, {4'h0, pin_out, pin_oe});
  endtask : t_reset

  // Overflow at modulo seven and the two-step clear.
  task automatic t_wrap();
    wr(4'h0, 8'h30);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h07);
    wr(4'h0, 8'h40);
    for (int i = 0; i < 40 && ovf_irq !== 1'b1; i++) @(posedge i_clk);
    bchk("ovf_irq", 1'b1, ovf_irq);
    wr(4'h0, 8'h60);
    bchk("no_arm", 1'b1, ovf_irq);
    wr(4'h0, 8'he0);
    bchk("one_wr", 1'b1, ovf_irq);
    rchk("flag", 4'h0, 8'he0);
    wr(4'h0, 8'h60);
    bchk("cleared", 1'b0, ovf_irq);
  endtask : t_wrap

  // Halt with counter reset, then a modulo high write that blocks the flag.
  task automatic t_block();
    wr(4'h0, 8'h70);
    repeat (10) @(posedge i_clk);
    rchk("hi0", 4'h1, 8'h00);
    rchk("lo0", 4'h2, 8'h00);
    rchk("trst", 4'h0, 8'h60);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h40);
    repeat (30) @(posedge i_clk);
    bchk("blocked", 1'b0, ovf_irq);
    wr(4'h4, 8'h07);
    repeat (30) @(posedge i_clk);
    bchk("unblock", 1'b1, ovf_irq);
    wr(4'h0, 8'h30);
  endtask : t_block

  // Each prescale code: about sixteen ticks over sixteen divided periods, none for code seven.
  task automatic t_div();
    wr(4'h3, 8'hff);
    wr(4'h4, 8'hff);
    for (int p = 0; p < 8; p++) begin
      wr(4'h0, 8'h30 | 8'(p));
      wr(4'h0, 8'(p));
      repeat ((16 << p) - 2) @(posedge i_clk);
      wr(4'h0, 8'h20 | 8'(p));
      rd(4'h1, c[15:8]);
      rd(4'h2, c[7:0]);
      chk("div", (p == 7) ? 8'h00 : 8'h04, 8'((c + 16'h0002) >> 2));
    end
  endtask : t_div

  // A second high read must not refresh the held low byte.
  task automatic t_latch();
    wr(4'h0, 8'h00);
    rd(4'h1, d);
    repeat (40) @(posedge i_clk);
    rd(4'h1, d);
    rd(4'h2, l1);
    rd(4'h2, l2);
    bchk("latch", 1'b1, (l2 - l1) > 8'd40);
  endtask : t_latch

  // Capture, preset, buffered pairing and compare on the channels.
  task automatic t_chan();
    wr(4'h0, 8'h30);
    pins.level(0, 1'b0);
    wr(4'h5, 8'h44);
    pins.level(0, 1'b1);
    repeat (4) @(posedge i_clk);
    bchk("cap", 1'b1, ch_irq[0]);
    wr(4'h5, 8'h44);
    bchk("no_arm", 1'b1, ch_irq[0]);
    rchk("ch0f", 4'h5, 8'hc4);
    wr(4'h5, 8'h44);
    bchk("ch_clr", 1'b0, ch_irq[0]);
    pins.level(0, 1'b0);
    repeat (4) @(posedge i_clk);
    bchk("fall", 1'b0, ch_irq[0]);
    wr(4'h5, 8'h10);
    repeat (2) @(posedge i_clk);
    chk("preset", 8'h00, {6'h0, pin_out[0], pin_oe[0]});
    wr(4'h8, 8'h14);
    bchk("oe1", 1'b1, pin_oe[1]);
    wr(4'h5, 8'h24);
    rchk("ch1_off", 4'h8, 8'h00);
    bchk("oe1_off", 1'b0, pin_oe[1]);
    rchk("unmapped", 4'hf, 8'h00);
    wr(4'h5, 8'h14);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h03);
    wr(4'h5, 8'h54);
    wr(4'h0, 8'h00);
    repeat (10) @(posedge i_clk);
    chk("cmp", 8'h07, {5'h0, ch_irq[0], pin_oe[0], pin_out[0]});
    // Compare and wrap at modulo five in one tick: the wrap toggle must beat the set action.
    wr(4'h0, 8'h30);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h05);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h05);
    wr(4'h5, 8'h1e);
    wr(4'h0, 8'h00);
    repeat (6) @(posedge i_clk);
    wr(4'h0, 8'h20);
    bchk("tov", 1'b0, pin_out[0]);
  endtask : t_chan

  // Verdict and end of run.
  task automatic test_done();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Main sequence after sixteen cycles of reset.
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_wrap();
    t_block();
    t_div();
    t_latch();
    t_chan();
    test_done();
  end

  // Watchdog well beyond the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    test_done();
  end
endmodule : tb_top

bind tccr_timer tccr_timer_sva sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
  .o_ovf_irq(o_ovf_irq), .o_ch_irq(o_ch_irq), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe));
